// ===== core/aprp_top.sv
// Purpose: Result readout port of a 16-bit converter, as it sits inside the device.
// Assumes: Host pins are asynchronous and pass two flip-flops before any logic reads them.
// Notes:   The conversion core is modelled by a fixed-length sequencer with the sample as an input.
// Contract
// - Reset low aborts any conversion immediately.
// - Reset low clears result latches to zero.
// - Chip select never gates reset.
// - Read strobe enables outputs only with select.
// - Bus shows last completed result, never partial.
// - Toggled select and strobe fetch each result.
// - Both held low shows each new result.
// - Drive only when select and strobe low.
// - Byte select low gives full word.
// - Byte select high: low byte up, ones below.
// - Busy high through conversion, falls at end.
`include "aprp_defs.svh"
module aprp_top #(
	parameter int RES_W      = `APRP_RES_W,
	parameter int CONV_CYCLES = `APRP_CONV_CYCLES
) (
	// System.
	input  wire logic             SYS_CLK_I,
	input  wire logic             SYS_RST_I,
	input  wire logic             CLK_EN_I,
	// Host control pins.
	input  wire logic             CHIP_SEL_N_I,
	input  wire logic             READ_N_I,
	input  wire logic             BYTE_SEL_I,
	input  wire logic             CONVERT_START_N_I,
	input  wire logic             RESET_N_I,
	// Converter core sample.
	input  wire logic [RES_W-1:0] SAMPLE_I,
	// Result bus pins and status.
	output logic      [RES_W-1:0] RESULT_BUS_PINS_O,
	output logic      [RES_W-1:0] RESULT_BUS_PINS_OE_N_O,
	output logic                  BUSY_O
);
	localparam int HB = RES_W / 2;

	aprp_pkg::aprp_ctl_t ctl_s1_q;
	aprp_pkg::aprp_ctl_t ctl_s2_q;
	logic                start_prev_q;
	aprp_pkg::aprp_state_t state_q;
	aprp_pkg::aprp_state_t state_d;
	logic [7:0]          cnt_q;
	logic [7:0]          cnt_d;
	logic [RES_W-1:0]    sample_q;
	logic [RES_W-1:0]    sample_d;
	logic [RES_W-1:0]    latch_q;
	logic                clr;
	logic                done;
	logic                start_fall;
	logic [RES_W-1:0]    bus_d;
	logic [RES_W-1:0]    bus_q;
	logic                oe_n_d;
	logic                oe_n_q;
	logic                busy_d;
	logic                busy_q;

	// Two-flop synchronisers on all host pins; only the second stage is read.
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ctl_s1_q     <= 5'h1f;
			ctl_s2_q     <= 5'h1f;
			start_prev_q <= 1'b1;
		end else if (CLK_EN_I) begin
			ctl_s1_q     <= '{CHIP_SEL_N_I, READ_N_I, BYTE_SEL_I, CONVERT_START_N_I, RESET_N_I};
			ctl_s2_q     <= ctl_s1_q;
			start_prev_q <= ctl_s2_q.start_n;
		end
	end

	assign clr        = !ctl_s2_q.rst_n;
	assign start_fall = start_prev_q && !ctl_s2_q.start_n && !ctl_s2_q.cs_n;
	assign done       = (state_q == aprp_pkg::APRP_CONV) && (cnt_q == `APRP_CNT_ONE);

	// Sequencer: the sample is captured at the start edge and converted for a fixed time.
	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		sample_d = sample_q;
		if (clr) begin
			state_d = aprp_pkg::APRP_IDLE;
			cnt_d   = `APRP_CNT_ZERO;
		end else begin
			case (state_q)
				aprp_pkg::APRP_IDLE, aprp_pkg::APRP_DONE: begin
					if (start_fall) begin
						state_d  = aprp_pkg::APRP_CONV;
						cnt_d    = 8'(CONV_CYCLES);
						sample_d = SAMPLE_I;
					end
				end
				aprp_pkg::APRP_CONV: begin
					cnt_d = cnt_q - `APRP_CNT_ONE;
					if (done) begin
						state_d = aprp_pkg::APRP_DONE;
					end
				end
				default: begin
					state_d = aprp_pkg::APRP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state_q  <= aprp_pkg::APRP_IDLE;
			cnt_q    <= `APRP_CNT_ZERO;
			sample_q <= `APRP_ZERO_RES;
		end else if (CLK_EN_I) begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			sample_q <= sample_d;
		end
	end

	// The latch only loads at completion, so a split byte read never mixes two results.
	aprp_latch #(
		.W(RES_W)
	) u_latch (
		.clk_i  (SYS_CLK_I),
		.rst_i  (SYS_RST_I),
		.en_i   (CLK_EN_I),
		.clr_i  (clr),
		.wr_i   (done),
		.wdata_i(sample_q),
		.rdata_o(latch_q)
	);

	// Output stage: with select and strobe held low, a new result flows out unasked.
	always_comb begin
		oe_n_d = ctl_s2_q.cs_n || ctl_s2_q.rd_n;
		busy_d = (state_d == aprp_pkg::APRP_CONV);
		if (ctl_s2_q.byte_sel) begin
			bus_d = {latch_q[HB-1:0], {HB{1'b1}}};
		end else begin
			bus_d = latch_q;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			bus_q  <= `APRP_ZERO_RES;
			oe_n_q <= 1'b1;
			busy_q <= 1'b0;
		end else if (CLK_EN_I) begin
			bus_q  <= bus_d;
			oe_n_q <= oe_n_d;
			busy_q <= busy_d;
		end
	end

	assign RESULT_BUS_PINS_O      = bus_q;
	assign RESULT_BUS_PINS_OE_N_O = {RES_W{oe_n_q}};
	assign BUSY_O                 = busy_q;

	property p_abort;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && clr |=> state_q == aprp_pkg::APRP_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("Conversion not aborted.");

	property p_clear;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && clr |=> latch_q == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("Latch not cleared.");

	property p_drive;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I |=> (oe_n_q == $past(ctl_s2_q.cs_n || ctl_s2_q.rd_n));
	endproperty
	a_drive: assert property (p_drive) else $error("Bus enable wrong.");

	property p_full;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && !ctl_s2_q.byte_sel |=> bus_q == $past(latch_q);
	endproperty
	a_full: assert property (p_full) else $error("Full word wrong.");

	property p_byte;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && ctl_s2_q.byte_sel |=> bus_q[HB-1:0] == {HB{1'b1}};
	endproperty
	a_byte: assert property (p_byte) else $error("Low lane not all ones.");

	sequence s_done;
		CLK_EN_I && done && !clr;
	endsequence
	property p_load;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		s_done |=> latch_q == $past(sample_q);
	endproperty
	a_load: assert property (p_load) else $error("Result not loaded.");

	property p_hold;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && !done && !clr |=> $stable(latch_q);
	endproperty
	a_hold: assert property (p_hold) else $error("Latch changed early.");

	property p_busy;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && state_q == aprp_pkg::APRP_CONV && !done && !clr |=> busy_q;
	endproperty
	a_busy: assert property (p_busy) else $error("Busy dropped early.");

	property p_busy_rise;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && start_fall && !clr && state_q != aprp_pkg::APRP_CONV |=> busy_q;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("Busy did not rise.");

	property p_busy_fall;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		s_done |=> !busy_q;
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("Busy did not fall.");

	property p_reset_free;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		CLK_EN_I && clr && ctl_s2_q.cs_n |=> !busy_q && latch_q == '0;
	endproperty
	a_reset_free: assert property (p_reset_free) else $error("Reset gated by select.");

	// A frozen conversion must keep its count, or it would finish early once released.
	property p_freeze;
		@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
		!CLK_EN_I |=> $stable(state_q) && $stable(cnt_q) && $stable(latch_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("State moved while frozen.");
endmodule

// ===== core/aprp_defs.svh
// Purpose: Constants for the converter result readout port.
// Assumes: A 200 MHz system clock with a 5 ns period.
// Notes:   Timing figures are kept in ns, and the cycle counts are derived from them.
`ifndef APRP_DEFS_SVH
`define APRP_DEFS_SVH
`define APRP_RES_W         16
`define APRP_BYTE_W        8
`define APRP_CLK_PERIOD_NS 5
`define APRP_CONV_TIME_NS  650
`define APRP_CONV_CYCLES   (`APRP_CONV_TIME_NS / `APRP_CLK_PERIOD_NS)
`define APRP_ONES_BYTE     8'hff
`define APRP_ZERO_RES      16'h0000
`define APRP_CNT_ONE       8'h01
`define APRP_CNT_ZERO      8'h00
`endif

// ===== core/aprp_pkg.sv
// Purpose: Types for the converter result readout port.
// Assumes: The constants header is included before this package.
// Notes:   The host-side controls travel together as one struct.
`include "aprp_defs.svh"
package aprp_pkg;
	typedef enum logic [2:0] {
		APRP_IDLE = 3'b001,
		APRP_CONV = 3'b010,
		APRP_DONE = 3'b100
	} aprp_state_t;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic byte_sel;
		logic start_n;
		logic rst_n;
	} aprp_ctl_t;
endpackage

// ===== core/aprp_latch.sv
// Purpose: Result holding latch that the bus reads from.
// Assumes: The write strobe comes from the sequencer on the same clock.
// Notes:   The read data comes straight out of a register.
`include "aprp_defs.svh"
module aprp_latch #(
	parameter int W = `APRP_RES_W
) (
	// Clock, reset and enable.
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         en_i,
	// Control.
	input  wire logic         clr_i,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wdata_i,
	// Read data.
	output logic      [W-1:0] rdata_o
);
	logic [W-1:0] data_q;
	logic [W-1:0] data_d;

	always_comb begin
		data_d = data_q;
		if (clr_i) begin
			data_d = '0;
		end else if (wr_i) begin
			data_d = wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_q <= '0;
		end else if (en_i) begin
			data_q <= data_d;
		end
	end

	assign rdata_o = data_q;
endmodule

// ===== tb/aprp_host.sv
// Purpose: Host model that drives the converter's control pins and sample.
// Assumes: Pins change by non-blocking assignment just after a rising edge.
// Notes:   Each level is held 4 edges so that it clears the 2-flop synchronisers.
module aprp_host (
	input  wire logic                clk_i,
	output aprp_pkg::aprp_ctl_t      ctl_o,
	output logic              [15:0] sample_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ctl_o = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
		sample_o = 16'h0000;
	end
	task automatic pins(input logic cs_n, input logic rd_n, input logic bs);
		@(posedge clk_i);
		ctl_o.cs_n <= cs_n;
		ctl_o.rd_n <= rd_n;
		ctl_o.byte_sel <= bs;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	// The caller keeps select low, as a start with select high is ignored.
	task automatic convert(input logic [15:0] s);
		@(posedge clk_i);
		sample_o <= s;
		ctl_o.start_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		ctl_o.start_n <= 1'b1;
	endtask
	task automatic dev_reset(input logic n);
		@(posedge clk_i);
		ctl_o.rst_n <= n;
		ctl_o.cs_n <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// ===== tb/adc_parallel_result_port_test.sv
// Purpose: Self-checking bench for the converter result readout port.
// Assumes: A conversion is shortened to 12 edges to keep the run short.
// Notes:   Outputs are sampled on the falling edge, clear of the launch edge.
module adc_parallel_result_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                sys_clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                clk_en = 1'b1;
	aprp_pkg::aprp_ctl_t ctl;
	logic         [15:0] sample;
	logic         [15:0] data;
	logic         [15:0] oe_n;
	logic                busy;
	int                  errors = 0;
	int                  compares = 0;
	always #2.5 sys_clk = ~sys_clk;
	aprp_host host_u (.clk_i(sys_clk), .ctl_o(ctl), .sample_o(sample));
	aprp_top #(.CONV_CYCLES(12)) dut_u (
		.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .CLK_EN_I(clk_en),
		.CHIP_SEL_N_I(ctl.cs_n), .READ_N_I(ctl.rd_n), .BYTE_SEL_I(ctl.byte_sel),
		.CONVERT_START_N_I(ctl.start_n), .RESET_N_I(ctl.rst_n), .SAMPLE_I(sample),
		.RESULT_BUS_PINS_O(data), .RESULT_BUS_PINS_OE_N_O(oe_n), .BUSY_O(busy));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (busy !== lvl && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		cmp({15'h0, busy}, {15'h0, lvl});
	endtask
	task automatic t_reset();
		@(negedge sys_clk);
		cmp(oe_n, 16'hffff);
		cmp(data, 16'h0000);
	endtask
	task automatic t_auto();
		host_u.pins(1'b0, 1'b0, 1'b0);
		host_u.convert(16'h1234);
		@(negedge sys_clk);
		cmp({15'h0, busy}, 16'h0001);
		cmp(data, 16'h0000);
		wait_busy(1'b0);
		repeat (2) @(negedge sys_clk);
		cmp(data, 16'h1234);
		host_u.convert(16'hbeef);
		wait_busy(1'b0);
		repeat (2) @(negedge sys_clk);
		cmp(data, 16'hbeef);
	endtask
	task automatic t_byte();
		host_u.pins(1'b0, 1'b0, 1'b1);
		cmp(data, 16'hefff);
		host_u.pins(1'b0, 1'b0, 1'b0);
		cmp(data, 16'hbeef);
		cmp(oe_n, 16'h0000);
	endtask
	task automatic t_gate();
		host_u.pins(1'b1, 1'b0, 1'b0);
		cmp(oe_n, 16'hffff);
		host_u.pins(1'b0, 1'b1, 1'b0);
		cmp(oe_n, 16'hffff);
	endtask
	task automatic t_toggle();
		host_u.convert(16'h5a5a);
		host_u.pins(1'b1, 1'b1, 1'b0);
		wait_busy(1'b0);
		host_u.pins(1'b0, 1'b0, 1'b0);
		cmp(data, 16'h5a5a);
		host_u.pins(1'b0, 1'b0, 1'b1);
		cmp(data, 16'h5aff);
		host_u.pins(1'b1, 1'b1, 1'b0);
		cmp(oe_n, 16'hffff);
	endtask
	// The abort lands well before the 12-edge conversion would end by itself.
	task automatic t_abort();
		host_u.pins(1'b0, 1'b1, 1'b0);
		host_u.convert(16'h0f0f);
		host_u.dev_reset(1'b0);
		@(negedge sys_clk);
		cmp({15'h0, busy}, 16'h0000);
		host_u.dev_reset(1'b1);
		host_u.pins(1'b0, 1'b0, 1'b0);
		cmp(data, 16'h0000);
	endtask
	// A conversion frozen by the clock enable must neither finish nor lose its place.
	task automatic t_freeze();
		host_u.convert(16'h3c3c);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		repeat (20) @(posedge sys_clk);
		clk_en <= 1'b1;
		@(negedge sys_clk);
		cmp({15'h0, busy}, 16'h0001);
		cmp(data, 16'h0000);
		wait_busy(1'b0);
		repeat (2) @(negedge sys_clk);
		cmp(data, 16'h3c3c);
	endtask
	task automatic wrap_up();
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_auto();
		t_byte();
		t_gate();
		t_toggle();
		t_abort();
		t_freeze();
		wrap_up();
	end
endmodule
